// *** bench/sgp_assertions.sv ***
`timescale 1ns/1ns
// Watches the bus answer and which pins the port may drive.
module sgp_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  input wire logic [3:0] panel_type
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A panel mode must be settled for a cycle before pins follow it.
  sequence s_panel;
    panel_type != 4'h0 && $past(panel_type) != 4'h0;
  endsequence
  AST_ANSWER: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("answer held too long");
  AST_ERR: assert property (pslverr |-> pready && paddr != 12'h064
    && paddr != 12'h048 && paddr != 12'h04c)
    else $error("error flag without unmapped access");
  AST_RST: assert property ($rose(presetn) |-> gpio_oe == 8'h00)
    else $error("pin driven after reset");
  AST_OE: assert property (s_panel |-> gpio_oe[3:2] == 2'h0)
    else $error("panel pins still driven");
  AST_OUT: assert property (s_panel |-> gpio_out[3:2] == 2'h0)
    else $error("panel pins carry port value");
  AST_RD: assert property ((s_panel and (pready && !pwrite &&
    paddr == 12'h064)) |-> prdata[3:2] == 2'h0)
    else $error("owned pins read nonzero");
  AST_OK: assert property (pready && paddr == 12'h064 |-> !pslverr)
    else $error("pin register refused");
endmodule

bind sgp_port sgp_assertions i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe), .panel_type(panel_type));

// *** bench/sgp_board.sv ***
`timescale 1ns/1ns
// Board side: the port wins where it drives, else the board level shows.
module sgp_board (
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  input wire logic [7:0] drive,
  output logic [7:0] pin
);
  assign pin = (gpio_oe & gpio_out) | (~gpio_oe & drive);
endmodule

// *** bench/shared_gpio_port_bench.sv ***
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module shared_gpio_port_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er;
  logic [7:0] gpio_out, gpio_oe, pin;
  logic [3:0] panel_type;
  int n_errors = 0, n_checks = 0;
  // Rows: write, address, write data, expected read data.
  logic [76:0] rows [11] = '{
    {1'b0, 12'h064, 32'h0, 32'h2000_0020}, {1'b1, 12'h064, 32'hff00_0000,
    32'h0}, {1'b0, 12'h064, 32'h0, 32'hff00_00a5}, {1'b1, 12'h064,
    32'h00f0_005a, 32'h0}, {1'b0, 12'h064, 32'h0, 32'h00f0_0050},
    {1'b1, 12'h04c, 32'hf, 32'h0}, {1'b0, 12'h064, 32'h0, 32'h00f0_0000},
    {1'b1, 12'h064, 32'hfff0_00ff, 32'h0}, {1'b1, 12'h04c, 32'h0, 32'h0},
    {1'b0, 12'h064, 32'h0, 32'hfff0_0055}, {1'b0, 12'h100, 32'h0, 32'h0}};
  always #50 pclk = ~pclk;
  sgp_port i_sgp_port (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio_in(pin),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .panel_type(panel_type));
  sgp_board i_board (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .drive(8'ha5), .pin(pin));
  // Idle gaps let pin changes pass the two sync flops before a read.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    repeat (3) @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Table cases, then each panel code, then a reset in mid-run.
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    foreach (rows[i]) begin
      apb(rows[i][76], rows[i][75:64], rows[i][63:32]);
      `CHK(er, rows[i][75:64] == 12'h100)
      if (!rows[i][76]) `CHK(rd, rows[i][31:0])
    end
    for (int c = 0; c < 5; c++) begin
      apb(1, 12'h048, c);
      apb(0, 12'h064, 0);
      `CHK(rd, c ? 32'hfff0_0051 : 32'hfff0_0055)
      `CHK(panel_type, c[3:0])
    end
    apb(1, 12'h064, 32'h00ff_0000);
    @(posedge pclk);
    `CHK(gpio_oe, 8'hf3)
    `CHK(gpio_out, 8'h00)
    presetn <= 0;
    @(posedge pclk);
    `CHK(gpio_oe, 8'h00)
    presetn <= 1;
    apb(0, 12'h064, 0);
    `CHK(rd, 32'h2000_0020)
    test_done;
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (3000) @(posedge pclk);
    n_errors++;
    test_done;
  end
endmodule

// *** rtl/sgp_consts.svh ***
`ifndef SGP_CONSTS_SVH
`define SGP_CONSTS_SVH

// Register byte offsets.
`define SGP_PIN_CTRL_OFS 12'h064
`define SGP_PANEL_SEL_OFS 12'h048
`define SGP_USB_SEL_OFS 12'h04c

// Field positions in the pin control/status register.
`define SGP_CS_LSB 0
`define SGP_DIR_LSB 16
`define SGP_IEN_LSB 24

// Reset values of the pin fields.
`define SGP_DIR_RST 8'h00
`define SGP_IEN_RST 8'h20
`define SGP_CS_RST 8'h00
`define SGP_PANEL_RST 4'h0
`define SGP_USB_RST 4'h0

// Pins that the panel and USB functions claim.
`define SGP_PANEL_PIN_MASK 8'h0c
`define SGP_USB_DP_BIT 7
`define SGP_USB_DM_BIT 6
`define SGP_USB_ATT_BIT 5
`define SGP_USB_PUP_BIT 4

`endif

// *** rtl/sgp_pkg.sv ***
package sgp_pkg;

  // Extended panel-type codes; anything else is reserved.
  typedef enum logic [3:0] {
    SGP_PANEL_NONE = 4'h0,
    SGP_PANEL_TFT2 = 4'h1,
    SGP_PANEL_TFT3 = 4'h2,
    SGP_PANEL_TFT4 = 4'h3,
    SGP_PANEL_VENDOR = 4'h4
  } sgp_panel_e;

  // Per-pin control fields of the shared port.
  typedef struct packed {
    logic [7:0] in_en;
    logic [7:0] dir;
    logic [7:0] ctl;
  } sgp_pins_s;

  // One APB request as seen by the slave.
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } sgp_req_s;

endpackage

// *** rtl/sgp_port.sv ***
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`include "sgp_consts.svh"
module sgp_port #(
  parameter int NUM_PINS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] gpio_in,
  output logic [7:0] gpio_out,
  output logic [7:0] gpio_oe,
  output logic [3:0] panel_type
);

  sgp_pkg::sgp_pins_s pins;
  sgp_pkg::sgp_pins_s next_pins;
  logic [3:0] next_panel_type;
  logic [3:0] usb_sel;
  logic [3:0] next_usb_sel;
  logic [7:0] next_gpio_out;
  logic [7:0] next_gpio_oe;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [7:0] pin_level;
  logic [7:0] owned;
  logic [7:0] in_live;
  logic access;
  sgp_pkg::sgp_req_s req;
  logic hit_pins;
  logic hit_panel;
  logic hit_usb;

  // The register packs eight pins into each byte-wide field, so any other
  // pin count would slide the fields over each other. Refuse it early
  // rather than build a port whose reads and writes disagree.
  if (NUM_PINS != 8) begin : g_bad_pins
    $error("sgp_port serves exactly eight pins");
  end

  // True for the pin register's word address.
  // Kept as a function because the write path, the read path and the
  // error flag all need the same answer, and three hand-written compares
  // could drift apart when an offset moves.
  function automatic logic is_pin_reg(input logic [11:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr == `SGP_PIN_CTRL_OFS) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // True for the panel-type word address.
  function automatic logic is_panel_reg(input logic [11:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr == `SGP_PANEL_SEL_OFS) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // True for the USB pin-claim word address.
  function automatic logic is_usb_reg(input logic [11:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr == `SGP_USB_SEL_OFS) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // Decode once per cycle; every consumer below reads these three flags.
  // Only whole aligned words are decoded, since the bus has no strobes.
  assign hit_pins = is_pin_reg(req.addr);
  assign hit_panel = is_panel_reg(req.addr);
  assign hit_usb = is_usb_reg(req.addr);

  // Pin levels come from outside the clock domain.
  // Two flops settle any metastable sample before logic looks at it; the
  // cost is that a read shows the pin as it was two clocks earlier.
  sgp_sync #(.WIDTH(8)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(gpio_in),
    .sync_out(pin_level)
  );

  // Pins currently claimed by the USB client or the panel.
  // The claim is worked out from registered state only, so the owned mask
  // never glitches while a bus write is still in flight.
  sgp_takeover u_take (
    .panel_type(panel_type),
    .usb_dp_on(usb_sel[3]),
    .usb_dm_on(usb_sel[2]),
    .usb_att_on(usb_sel[1]),
    .usb_pup_on(usb_sel[0]),
    .owned(owned)
  );

  // The bus request travels as one bundle so the decode sees a single
  // consistent snapshot of address, direction and data.
  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

  // Answer in the second access cycle; pready is a flop so one wait state.
  // Masking with pready stops the second access cycle, in which the
  // master still holds the request, from taking the same write twice.
  assign access = psel && penable && !pready;

  // Register writes; owned pins keep their control bit untouched.
  // The enable and direction fields stay writable on owned pins, because
  // software must be able to set the panel pins' direction while they are owned, ready for when they are released.
  always_comb begin
    next_pins = pins;
    next_panel_type = panel_type;
    next_usb_sel = usb_sel;
    if (access && req.write) begin
      if (hit_pins) begin
        next_pins.in_en = req.wdata[`SGP_IEN_LSB +: 8];
        next_pins.dir = req.wdata[`SGP_DIR_LSB +: 8];
        next_pins.ctl = (pins.ctl & owned)
          | (req.wdata[`SGP_CS_LSB +: 8] & ~owned);
      end else if (hit_panel) begin
        next_panel_type = req.wdata[3:0];
      end else if (hit_usb) begin
        next_usb_sel = req.wdata[3:0];
      end
    end
  end

  // Register state. Reset puts every pin back to an input with only the
  // attach-sense pin's input enable set, and releases every claim.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins.in_en <= `SGP_IEN_RST;
      pins.dir <= `SGP_DIR_RST;
      pins.ctl <= `SGP_CS_RST;
      panel_type <= `SGP_PANEL_RST;
      usb_sel <= `SGP_USB_RST;
    end else begin
      pins <= next_pins;
      panel_type <= next_panel_type;
      usb_sel <= next_usb_sel;
    end
  end

  // Per-pin logic: the same few gates repeat for every pin, so one loop
  // builds them all and a pin can never be left out by a typing slip.
  for (genvar p = 0; p < 8; p++) begin : g_pin
    // An input reads live only when enabled; outputs skip the enable.
    // A disabled input reads as zero rather than a floating level.
    assign in_live[p] = pin_level[p]
      && (pins.in_en[p] || pins.dir[p]);
    // Drive is released while a pin is owned, since the owning function
    // then drives it through its own path and the two must not fight.
    assign next_gpio_oe[p] = pins.dir[p]
      && !owned[p];
    assign next_gpio_out[p] = pins.ctl[p] && !owned[p];
  end

  // Read data and the one-wait-state handshake.
  // Read data is zero outside an answer, so a stale word never sits on
  // the bus where a careless master might take it.
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pready = access;
    next_pslverr = 1'b0;
    if (access && !req.write) begin
      if (hit_pins) begin
        next_prdata[`SGP_IEN_LSB +: 8] = pins.in_en;
        next_prdata[`SGP_DIR_LSB +: 8] = pins.dir;
        // Owned pins read zero.
        next_prdata[`SGP_CS_LSB +: 8] = in_live & ~owned;
      end else if (hit_panel) begin
        next_prdata[3:0] = panel_type;
      end else if (hit_usb) begin
        next_prdata[3:0] = usb_sel;
      end else begin
        next_pslverr = 1'b1;
      end
    end else if (access) begin
      // Writes to unmapped words are dropped but still flagged.
      next_pslverr = !(hit_pins || hit_panel || hit_usb);
    end
  end

  // Outputs all come straight from flops, so the pins and the bus see
  // no decode glitches; the price is one clock of extra latency.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      gpio_out <= 8'h00;
      gpio_oe <= 8'h00;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      gpio_out <= next_gpio_out;
      gpio_oe <= next_gpio_oe;
    end
  end

endmodule

// *** rtl/sgp_sync.sv ***
`timescale 1ns/1ns
// Two-flop synchroniser for the pin levels.
module sgp_sync #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;

  // Only the second stage reads the first one.
  always_comb begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule

// *** rtl/sgp_takeover.sv ***
`timescale 1ns/1ns
`include "sgp_consts.svh"
// Works out which pins the USB client or panel currently own.
module sgp_takeover (
  input wire logic [3:0] panel_type,
  input wire logic usb_dp_on,
  input wire logic usb_dm_on,
  input wire logic usb_att_on,
  input wire logic usb_pup_on,
  output logic [7:0] owned
);

  // Any non-zero panel code is an override, reserved codes included.
  always_comb begin
    owned = 8'h00;
    if (sgp_pkg::sgp_panel_e'(panel_type) != sgp_pkg::SGP_PANEL_NONE) begin
      owned = `SGP_PANEL_PIN_MASK;
    end
    owned[`SGP_USB_DP_BIT] = usb_dp_on;
    owned[`SGP_USB_DM_BIT] = usb_dm_on;
    owned[`SGP_USB_ATT_BIT] = usb_att_on;
    owned[`SGP_USB_PUP_BIT] = usb_pup_on;
  end

endmodule
